// ==== core/flash_lock_access_checker.sv ====
`timescale 1ns/100ps

// How it works
// [RULE1] unlocked pages except lock-byte page and reserved area: permitted from every source
// [RULE2] locked pages: debug ignored, unlocked fw faults, locked fw permitted
// [RULE3] lock-byte page read/write free if none locked, else locked-page rules
// [RULE4] reading lock byte free if none locked, else locked-page rules
// [RULE5] none locked: lock-page erase allowed from debug, firmware faults
// [RULE6] any locked: only debug device erase clears it; firmware erase faults
// [RULE7] clearing lock bits one to zero: permitted while lock byte erased, once written debug ignored, firmware faults
// [RULE8] setting lock bits zero to one: debug ignored, firmware faults
// [RULE9] reserved area access: debug ignored, firmware faults
// [RULE10] fault resets device and flash fault flag reads 1 afterwards
// [RULE11] refused debug accesses are dropped with no reset request
// [RULE12] any locked page makes the lock-byte page locked too
// [RULE13] written lock byte frozen except by debug device erase; code also lets debug lock-page erase clear it while no lock bit is latched
// [RULE14] lock state latched only at reset
// [RULE15] lock page, reserved area and bit mapping are parameters
// [RULE16] fault suppresses operation and pulses reset request same cycle
module flash_lock_access_checker #(
  parameter logic [14:0] LOCK_PAGE = flash_lock_pkg::LOCK_PAGE_ADDR, // RULE15
  parameter logic [14:0] RSVD_LO = flash_lock_pkg::RSVD_BASE,
  parameter logic [14:0] RSVD_LEN = flash_lock_pkg::RSVD_SIZE,
  parameter int PAGE_SHIFT = flash_lock_pkg::PAGE_W,
  parameter int NUM_LOCK = flash_lock_pkg::LOCK_BITS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // access request from core or debug interface
  input wire flash_lock_pkg::req_s req,
  // stored lock byte value as read from the array
  input wire logic [7:0] lock_byte_q,
  // reset cause flag from a previous flash fault, kept by the reset controller
  input wire logic flash_fault_flag_in,
  // decision and flash strobe
  output flash_lock_pkg::ans_s ans,
  output logic flash_go,
  output logic flash_wr_lock_byte,
  output logic flash_fault_rst_req,
  output logic flash_fault_flag,
  output logic [7:0] lock_state
);

  // lock byte has eight bits, so more lock bits cannot be served
  if (PAGE_SHIFT < 1 || PAGE_SHIFT > 14 || NUM_LOCK < 1 || NUM_LOCK > 8)
  begin : g_bad_geometry
    $error("unsupported lock geometry");
  end

  logic rst_s1_ff, rst_s2_ff;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire rst_n = rst_s2_ff;

  // lock state captured only on the third clock after nrst release, the first after the two-stage synchroniser lets go
  logic [7:0] lock_ff, nxt_lock;
  logic cap_ff, nxt_cap;
  logic flag_ff, nxt_flag;
  always_comb
  begin
    nxt_lock = lock_ff;
    nxt_cap = 1'b1;
    nxt_flag = flag_ff;
    if (!cap_ff)
    begin
      nxt_lock = lock_byte_q; // RULE14
      nxt_flag = flash_fault_flag_in; // RULE10
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_ff <= flash_lock_pkg::LOCK_RESET_VAL;
      cap_ff <= 1'b0;
      flag_ff <= 1'b0;
    end
    else
    begin
      lock_ff <= nxt_lock;
      cap_ff <= nxt_cap;
      flag_ff <= nxt_flag;
    end
  end

  logic any_locked, on_lock_page, in_rsvd, page_locked, is_lock_byte;
  logic [14:0] pg;
  always_comb
  begin
    pg = req.addr >> PAGE_SHIFT;
    any_locked = ~&lock_ff[NUM_LOCK-1:0];
    on_lock_page = (req.addr >> PAGE_SHIFT) == (LOCK_PAGE >> PAGE_SHIFT);
    in_rsvd = (req.addr >= RSVD_LO) && (req.addr < RSVD_LO + RSVD_LEN); // RULE9
    is_lock_byte = req.addr == flash_lock_pkg::LOCK_BYTE_ADDR;
    page_locked = (pg < 15'(NUM_LOCK)) && !lock_ff[pg[2:0]]; // RULE15
  end

  // decision: ignore for debug, fault for firmware whenever prohibited
  flash_lock_pkg::dec_e dec, deny;
  always_comb
  begin
    deny = (req.src == flash_lock_pkg::SRC_DEBUG) ? flash_lock_pkg::DEC_IGNORE
                                                  : flash_lock_pkg::DEC_FAULT; // RULE11
    dec = flash_lock_pkg::DEC_PERMIT; // RULE1
    if (req.op == flash_lock_pkg::OP_DEVICE_ERASE)
      dec = deny == flash_lock_pkg::DEC_IGNORE ? flash_lock_pkg::DEC_PERMIT : deny; // RULE6
    else if (in_rsvd)
      dec = deny; // RULE9
    else if (on_lock_page)
    begin
      if (req.op == flash_lock_pkg::OP_ERASE)
      begin
        if (any_locked || req.src != flash_lock_pkg::SRC_DEBUG)
          dec = deny; // RULE5 RULE6
      end
      else if (is_lock_byte && req.op == flash_lock_pkg::OP_WRITE
               && lock_byte_q != flash_lock_pkg::LOCK_BYTE_ERASED)
        dec = deny; // RULE7 RULE8 RULE13
      else if (any_locked && req.src != flash_lock_pkg::SRC_FW_LOCKED)
        dec = deny; // RULE3 RULE4 RULE12
    end
    else if (page_locked && req.src != flash_lock_pkg::SRC_FW_LOCKED)
      dec = deny; // RULE2
    // everything else stays permitted
  end

  always_comb
  begin
    ans.valid = req.valid;
    ans.dec = dec;
    flash_go = req.valid && dec == flash_lock_pkg::DEC_PERMIT; // RULE16
    flash_fault_rst_req = req.valid && dec == flash_lock_pkg::DEC_FAULT; // RULE16 RULE10
    flash_wr_lock_byte = flash_go && is_lock_byte && req.op == flash_lock_pkg::OP_WRITE;
    flash_fault_flag = flag_ff;
    lock_state = lock_ff;
  end

  property p_dbg_no_reset;
    @(posedge sys_clk) disable iff (!rst_n)
    req.valid && req.src == flash_lock_pkg::SRC_DEBUG |-> !flash_fault_rst_req;
  endproperty
  a_dbg_no_reset: assert property (p_dbg_no_reset) else $error("debug caused reset"); // RULE11

  property p_fault_no_go;
    @(posedge sys_clk) disable iff (!rst_n)
    flash_fault_rst_req |-> !flash_go;
  endproperty
  a_fault_no_go: assert property (p_fault_no_go) else $error("fault with flash op"); // RULE16

  property p_rsvd;
    @(posedge sys_clk) disable iff (!rst_n)
    req.valid && in_rsvd && req.op != flash_lock_pkg::OP_DEVICE_ERASE |-> !flash_go;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved access allowed"); // RULE9

  property p_lock_stable;
    @(posedge sys_clk) disable iff (!rst_n)
    cap_ff |=> $stable(lock_ff);
  endproperty
  a_lock_stable: assert property (p_lock_stable) else $error("lock changed after reset"); // RULE14

  property p_fw_locked_page;
    @(posedge sys_clk) disable iff (!rst_n)
    req.valid && req.src == flash_lock_pkg::SRC_FW_UNLOCKED && page_locked && !in_rsvd
      && !on_lock_page && req.op != flash_lock_pkg::OP_DEVICE_ERASE |-> flash_fault_rst_req;
  endproperty
  a_fw_locked_page: assert property (p_fw_locked_page) else $error("no fault on locked page"); // RULE2

  property p_fw_erase_lockpage;
    @(posedge sys_clk) disable iff (!rst_n)
    req.valid && req.src != flash_lock_pkg::SRC_DEBUG && on_lock_page && !in_rsvd
      && req.op == flash_lock_pkg::OP_ERASE |-> flash_fault_rst_req;
  endproperty
  a_fw_erase_lockpage: assert property (p_fw_erase_lockpage) else $error("fw lock erase"); // RULE5

  property p_lockbyte_frozen;
    @(posedge sys_clk) disable iff (!rst_n)
    req.valid && is_lock_byte && !in_rsvd && req.op == flash_lock_pkg::OP_WRITE
      && lock_byte_q != flash_lock_pkg::LOCK_BYTE_ERASED |-> !flash_wr_lock_byte;
  endproperty
  a_lockbyte_frozen: assert property (p_lockbyte_frozen) else $error("lock byte rewritten"); // RULE13

  property p_unlocked_ok;
    @(posedge sys_clk) disable iff (!rst_n)
    req.valid && !page_locked && !on_lock_page && !in_rsvd
      && req.op != flash_lock_pkg::OP_DEVICE_ERASE |-> flash_go;
  endproperty
  a_unlocked_ok: assert property (p_unlocked_ok) else $error("unlocked access blocked"); // RULE1

  property p_lockpage_any;
    @(posedge sys_clk) disable iff (!rst_n)
    req.valid && any_locked && on_lock_page && !in_rsvd && req.src == flash_lock_pkg::SRC_DEBUG
      && req.op != flash_lock_pkg::OP_DEVICE_ERASE |-> !flash_go;
  endproperty
  a_lockpage_any: assert property (p_lockpage_any) else $error("debug reached locked page"); // RULE12

  property p_lockpage_fw;
    @(posedge sys_clk) disable iff (!rst_n)
    req.valid && any_locked && on_lock_page && req.src == flash_lock_pkg::SRC_FW_UNLOCKED
      && req.op != flash_lock_pkg::OP_DEVICE_ERASE |-> flash_fault_rst_req;
  endproperty
  a_lockpage_fw: assert property (p_lockpage_fw) else $error("fw reached locked lock page"); // RULE3

  property p_dev_erase;
    @(posedge sys_clk) disable iff (!rst_n)
    req.valid && req.op == flash_lock_pkg::OP_DEVICE_ERASE
      |-> flash_go == (req.src == flash_lock_pkg::SRC_DEBUG);
  endproperty
  a_dev_erase: assert property (p_dev_erase) else $error("device erase decided wrongly"); // RULE6

  // capture edge is the only one where the stored values may enter
  property p_flag_capture;
    @(posedge sys_clk) disable iff (!rst_n)
    !cap_ff |=> flag_ff == $past(flash_fault_flag_in);
  endproperty
  a_flag_capture: assert property (p_flag_capture) else $error("fault flag lost over reset"); // RULE10

  property p_lock_capture;
    @(posedge sys_clk) disable iff (!rst_n)
    !cap_ff |=> lock_ff == $past(lock_byte_q);
  endproperty
  a_lock_capture: assert property (p_lock_capture) else $error("lock state not taken at reset"); // RULE14

  c_fault: cover property (@(posedge sys_clk) disable iff (!rst_n) flash_fault_rst_req);
  c_ignore: cover property (@(posedge sys_clk) disable iff (!rst_n)
    req.valid && dec == flash_lock_pkg::DEC_IGNORE);
  c_dev_erase: cover property (@(posedge sys_clk) disable iff (!rst_n)
    flash_go && req.op == flash_lock_pkg::OP_DEVICE_ERASE);
  c_lock_write: cover property (@(posedge sys_clk) disable iff (!rst_n) flash_wr_lock_byte);

endmodule // flash_lock_access_checker

// ==== shared/flash_lock_pkg.sv ====
package flash_lock_pkg;

  // geometry defaults
  localparam int ADDR_W = 15;
  localparam int PAGE_W = 9;
  localparam int LOCK_BITS = 8;
  localparam logic [14:0] LOCK_PAGE_ADDR = 15'h7E00;
  localparam logic [14:0] RSVD_BASE = 15'h7C00;
  localparam logic [14:0] RSVD_SIZE = 15'h0200;
  localparam logic [14:0] LOCK_BYTE_ADDR = 15'h7FFF;
  localparam logic [7:0] LOCK_BYTE_ERASED = 8'hFF;
  localparam logic [7:0] LOCK_RESET_VAL = 8'hFF;

  typedef enum logic [1:0] {SRC_DEBUG, SRC_FW_UNLOCKED, SRC_FW_LOCKED} src_e;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ERASE, OP_DEVICE_ERASE} op_e;
  typedef enum logic [1:0] {DEC_PERMIT, DEC_IGNORE, DEC_FAULT} dec_e;

  typedef struct packed {
    logic valid;
    src_e src;
    op_e op;
    logic [14:0] addr;
    logic [7:0] wdata;
  } req_s;

  typedef struct packed {
    logic valid;
    dec_e dec;
  } ans_s;

endpackage

// ==== tb/flash_lock_access_checker_tb.sv ====
`timescale 1ns/100ps
module flash_lock_access_checker_tb;
  localparam flash_lock_pkg::src_e D = flash_lock_pkg::SRC_DEBUG;
  localparam flash_lock_pkg::src_e U = flash_lock_pkg::SRC_FW_UNLOCKED;
  localparam flash_lock_pkg::src_e L = flash_lock_pkg::SRC_FW_LOCKED;
  localparam flash_lock_pkg::op_e RD = flash_lock_pkg::OP_READ;
  localparam flash_lock_pkg::op_e WR = flash_lock_pkg::OP_WRITE;
  localparam flash_lock_pkg::op_e ER = flash_lock_pkg::OP_ERASE;
  localparam flash_lock_pkg::op_e DE = flash_lock_pkg::OP_DEVICE_ERASE;
  localparam flash_lock_pkg::dec_e P = flash_lock_pkg::DEC_PERMIT;
  localparam flash_lock_pkg::dec_e I = flash_lock_pkg::DEC_IGNORE;
  localparam flash_lock_pkg::dec_e F = flash_lock_pkg::DEC_FAULT;
  logic sys_clk = 1'h0;
  logic nrst = 1'h0;
  logic load = 1'h1;
  logic [7:0] load_val = 8'hFF;
  flash_lock_pkg::req_s req = '0;
  flash_lock_pkg::ans_s ans;
  logic [7:0] lock_byte_q;
  logic [7:0] lock_state;
  logic flash_fault_flag_in;
  logic flash_go;
  logic flash_wr_lock_byte;
  logic flash_fault_rst_req;
  logic flash_fault_flag;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  flash_lock_access_checker DUT (.sys_clk, .nrst, .req, .lock_byte_q, .flash_fault_flag_in, .ans, .flash_go,
    .flash_wr_lock_byte, .flash_fault_rst_req, .flash_fault_flag, .lock_state);
  flash_side_model far_side (.sys_clk, .load, .load_val, .req, .flash_go, .flash_wr_lock_byte,
    .flash_fault_rst_req, .lock_byte_q, .flash_fault_flag_in);
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    $display("errors %0d checked %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic fail(input string msg);
    n_errors++;
    $display("FAIL %0t %s", $time, msg);
  endtask
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
      fail("value mismatch");
  endtask
  // request held one full cycle so the far side sees it at the rising edge
  task automatic acc(input flash_lock_pkg::src_e s, input flash_lock_pkg::op_e o, input logic [14:0] a,
    input flash_lock_pkg::dec_e e, input logic [7:0] d = 8'h00);
    @(negedge sys_clk);
    req = '{1'h1, s, o, a, d};
    #5;
    samples_checked++;
    if (ans.valid !== 1'h1 || ans.dec !== e || flash_go !== (e == P) || flash_fault_rst_req !== (e == F))
      fail("decision mismatch");
  endtask
  task automatic do_reset(input logic ld, input logic [7:0] v);
    @(negedge sys_clk);
    req.valid = 1'h0;
    nrst = 1'h0;
    load = ld;
    load_val = v;
    repeat (12) @(negedge sys_clk);
    load = 1'h0;
    nrst = 1'h1;
    repeat (4) @(negedge sys_clk);
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      final_report();
    end
  end
  initial
  begin
    do_reset(1'h1, 8'hFF);
    cmp_val(flash_fault_flag, 8'h00);
    acc(D, RD, 15'h0000, P);
    acc(U, WR, 15'h7E10, P);
    acc(D, RD, 15'h7FFF, P);
    acc(D, ER, 15'h7E00, P);
    acc(U, ER, 15'h7E00, F);
    acc(L, ER, 15'h7E00, F);
    acc(D, RD, 15'h7C00, I);
    acc(L, WR, 15'h7DFF, F);
    acc(U, WR, 15'h7FFF, P, 8'hFE);
    cmp_val(flash_wr_lock_byte, 8'h01);
    acc(U, RD, 15'h0000, P);
    cmp_val(lock_state, 8'hFF);
    acc(L, WR, 15'h7FFF, F, 8'h00);
    do_reset(1'h0, 8'h00);
    cmp_val(lock_state, 8'hFE);
    cmp_val(flash_fault_flag, 8'h01);
    acc(D, RD, 15'h0000, I);
    cmp_val(flash_wr_lock_byte, 8'h00);
    acc(U, WR, 15'h01FF, F);
    acc(L, ER, 15'h0000, P);
    acc(D, WR, 15'h0200, P);
    acc(D, RD, 15'h7E00, I);
    acc(U, WR, 15'h7E01, F);
    acc(L, RD, 15'h7FFF, P);
    acc(U, RD, 15'h7FFF, F);
    acc(L, ER, 15'h7E00, F);
    acc(D, ER, 15'h7E00, I);
    acc(D, WR, 15'h7FFF, I, 8'h7E);
    acc(L, WR, 15'h7FFF, F, 8'hFF);
    acc(D, DE, 15'h0000, P);
    do_reset(1'h0, 8'h00);
    cmp_val(lock_state, 8'hFF);
    final_report();
  end
endmodule // flash_lock_access_checker_tb

// ==== tb/flash_side_model.sv ====
`timescale 1ns/100ps
// flash array holding the lock byte, and the reset controller's fault cause
module flash_side_model (
  // clock and bench preload
  input wire logic sys_clk,
  input wire logic load,
  input wire logic [7:0] load_val,
  // from the checker
  input wire flash_lock_pkg::req_s req,
  input wire logic flash_go,
  input wire logic flash_wr_lock_byte,
  input wire logic flash_fault_rst_req,
  // to the checker
  output logic [7:0] lock_byte_q,
  output logic flash_fault_flag_in
);
  // cause survives device reset; only the bench preload clears it
  always @(posedge sys_clk)
  begin
    if (load)
    begin
      lock_byte_q <= load_val;
      flash_fault_flag_in <= 1'h0;
    end
    else
    begin
      if (flash_wr_lock_byte)
        lock_byte_q <= req.wdata;
      if (flash_go && req.op == flash_lock_pkg::OP_ERASE
          && (req.addr >> flash_lock_pkg::PAGE_W) == (flash_lock_pkg::LOCK_BYTE_ADDR >> flash_lock_pkg::PAGE_W))
        lock_byte_q <= flash_lock_pkg::LOCK_BYTE_ERASED;
      if (flash_go && req.op == flash_lock_pkg::OP_DEVICE_ERASE)
        lock_byte_q <= flash_lock_pkg::LOCK_BYTE_ERASED;
      if (flash_fault_rst_req)
        flash_fault_flag_in <= 1'h1;
    end
  end
endmodule // flash_side_model
